// ===== logic/flash_command_protection_ctrl.sv
// Purpose: Command front end, erase sequencer, protection and burst stall
// Assumes: Select, write, lock and supply pins sampled through three flops; one clock
// Notes:   Array core is external; erase result comes from erase_fail
// Operation
// - Stall once crossing first 16-word boundary
// - Four-word aligned start gives no stall
// - Start at group end stalls latency code
// - Stall at most once, only on crossing
// - Stall indicator output shows the boundary stall
// - Erase starts only after 20H then D0H
// - Bits 4 and 5 flag bad sequence
// - Bit 5 alone flags erase failure
// - Bit 1 flags lock pin refusal
// - Low program supply fails all, bit 3
// - Error bits sticky until clear-status command
// - FFH write returns to read-array mode
// - Lock pin low fails lockable blocks
// - Lockable: main plus two boot blocks
// - Reset disables device, all blocks locked
// - Deselected in read-array mode: standby, outputs float
// - Deselect during erase finishes operation first
// - Write taken only with select and strobe low
// - Array changes only after full sequence
// - Read-array mode after power-up or reset
// - After erase stay in status mode
// - After array read enter idle power saving
`include "flash_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_command_protection_ctrl #(
  parameter int ERASE_CYCLES = `ERASE_CYCLES,
  parameter bit TOP_BOOT     = 1'b1,
  parameter int NUM_BLOCKS   = 23
) (
  input  wire  logic                   sys_clk,
  input  wire  logic                   nrst,
  input  wire  logic                   chip_sel_n,
  input  wire  logic                   write_n,
  input  wire  logic                   out_en_n,
  input  wire  logic                   write_protect_n,
  input  wire  logic                   supply_ok,
  input  wire  logic [7:0]             cmd_data,
  input  wire  logic [4:0]             cmd_block,
  input  wire  logic                   burst_start,
  input  wire  logic                   burst_next,
  input  wire  logic                   burst_continuous,
  input  wire  logic [3:0]             burst_addr,
  input  wire  logic [2:0]             latency_code,
  input  wire  logic                   erase_fail,
  input  wire  logic [15:0]            array_data,
  output logic [7:0]                   operation_status,
  output logic [15:0]                  dq_out,
  output logic                         dq_oe_n,
  output logic                         stall_n,
  output logic                         erase_go,
  output logic [4:0]                   erase_block,
  output logic                         idle_power_saving,
  output logic                         standby
);
  import flash_ctrl_pkg::*;

  function automatic logic lockable(input logic [4:0] b);
    if (TOP_BOOT)
      lockable = (b < 5'h0f) || (b == 5'h15) || (b == 5'h16);
    else
      lockable = (b > 5'h07) || (b == 5'h00) || (b == 5'h01);
  endfunction

  // Pin synchronisers: three flops, change taken when last two agree
  logic [2:0] cs_s_r, we_s_r, wp_s_r, vpp_s_r;
  logic       cs_n_r, we_n_r, wp_n_r, vpp_ok_r;
  logic       cs_n_nxt, we_n_nxt, wp_n_nxt, vpp_ok_nxt;
  always_comb begin
    cs_n_nxt   = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_n_r;
    we_n_nxt   = (we_s_r[1] == we_s_r[2]) ? we_s_r[2] : we_n_r;
    wp_n_nxt   = (wp_s_r[1] == wp_s_r[2]) ? wp_s_r[2] : wp_n_r;
    vpp_ok_nxt = (vpp_s_r[1] == vpp_s_r[2]) ? vpp_s_r[2] : vpp_ok_r;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_s_r   <= 3'h7;
      we_s_r   <= 3'h7;
      wp_s_r   <= 3'h0;
      vpp_s_r  <= 3'h0;
      cs_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      wp_n_r   <= 1'b0;
      vpp_ok_r <= 1'b0;
    end else begin
      cs_s_r   <= {cs_s_r[1:0], chip_sel_n};
      we_s_r   <= {we_s_r[1:0], write_n};
      wp_s_r   <= {wp_s_r[1:0], write_protect_n};
      vpp_s_r  <= {vpp_s_r[1:0], supply_ok};
      cs_n_r   <= cs_n_nxt;
      we_n_r   <= we_n_nxt;
      wp_n_r   <= wp_n_nxt;
      vpp_ok_r <= vpp_ok_nxt;
    end
  end

  // Command front end and write state machine
  read_mode_e mode_r, mode_nxt;
  wsm_state_e wsm_r, wsm_nxt;
  logic [7:0]  status_r, status_nxt;
  logic [4:0]  blk_r, blk_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        wr_seen_r, wr_seen_nxt;
  logic        go_r, go_nxt;
  logic        wr_stb;
  logic        busy;
  assign busy   = (wsm_r == WSM_ERASE);
  assign wr_stb = !cs_n_r && !we_n_r && !wr_seen_r;

  always_comb begin
    mode_nxt    = mode_r;
    wsm_nxt     = wsm_r;
    status_nxt  = status_r;
    blk_nxt     = blk_r;
    cnt_nxt     = cnt_r;
    go_nxt      = 1'b0;
    wr_seen_nxt = !cs_n_r && !we_n_r;
    case (wsm_r)
      WSM_ERASE: begin
        // Runs to completion whatever chip select does
        if (cnt_r == 16'h0000) begin
          wsm_nxt = WSM_IDLE;
          status_nxt[`SR_READY] = 1'b1;
          if (erase_fail)
            status_nxt[`SR_ERASE_ERR] = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      WSM_IDLE: begin
        if (wr_stb) begin
          if (mode_r == MODE_SETUP) begin
            mode_nxt = MODE_STATUS;
            if (cmd_data != `CMD_ERASE_CONFIRM) begin
              status_nxt[`SR_ERASE_ERR] = 1'b1;
              status_nxt[`SR_SEQ_ERR]   = 1'b1;
            end else if (!vpp_ok_r) begin
              status_nxt[`SR_SUPPLY_ERR] = 1'b1;
            end else if (!wp_n_r && lockable(cmd_block)) begin
              status_nxt[`SR_LOCK_ERR]  = 1'b1;
              status_nxt[`SR_ERASE_ERR] = 1'b1;
            end else begin
              wsm_nxt = WSM_ERASE;
              blk_nxt = cmd_block;
              go_nxt  = 1'b1;
              cnt_nxt = 16'(ERASE_CYCLES - 1);
              status_nxt[`SR_READY] = 1'b0;
            end
          end else begin
            case (cmd_data)
              `CMD_READ_ARRAY:   mode_nxt = MODE_ARRAY;
              `CMD_READ_STATUS:  mode_nxt = MODE_STATUS;
              `CMD_ERASE_SETUP:  mode_nxt = MODE_SETUP;
              `CMD_CLEAR_STATUS: status_nxt = `SR_RESET;
              default: begin
                mode_nxt = MODE_STATUS;
                status_nxt[`SR_ERASE_ERR] = 1'b1;
                status_nxt[`SR_SEQ_ERR]   = 1'b1;
              end
            endcase
          end
        end
      end
      default: wsm_nxt = WSM_IDLE;
    endcase
  end

  // Reset forces read-array, idle, nothing erasing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r    <= MODE_ARRAY;
      wsm_r     <= WSM_IDLE;
      status_r  <= `SR_RESET;
      blk_r     <= 5'h00;
      cnt_r     <= 16'h0000;
      wr_seen_r <= 1'b0;
      go_r      <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      wsm_r     <= wsm_nxt;
      status_r  <= status_nxt;
      blk_r     <= blk_nxt;
      cnt_r     <= cnt_nxt;
      wr_seen_r <= wr_seen_nxt;
      go_r      <= go_nxt;
    end
  end

  // Continuous burst boundary stall
  logic [2:0] stall_cnt_r, stall_cnt_nxt;
  logic [3:0] addr_r, addr_nxt;
  logic       stall_done_r, stall_done_nxt;
  logic       in_burst_r, in_burst_nxt;
  always_comb begin
    stall_cnt_nxt  = stall_cnt_r;
    addr_nxt       = addr_r;
    stall_done_nxt = stall_done_r;
    in_burst_nxt   = in_burst_r;
    if (burst_start && burst_continuous) begin
      in_burst_nxt   = 1'b1;
      addr_nxt       = burst_addr;
      stall_cnt_nxt  = 3'h0;
      stall_done_nxt = (burst_addr[1:0] == 2'b00);
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_nxt = stall_cnt_r - 3'h1;
    end else if (in_burst_r && burst_next) begin
      addr_nxt = addr_r + 4'h1;
      if (addr_r == 4'hf && !stall_done_r) begin
        stall_done_nxt = 1'b1;
        // Any start not four-word aligned pays the full latency
        stall_cnt_nxt  = latency_code;
      end
    end
    if (cs_n_r)
      in_burst_nxt = 1'b0;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_r  <= 3'h0;
      addr_r       <= 4'h0;
      stall_done_r <= 1'b1;
      in_burst_r   <= 1'b0;
    end else begin
      stall_cnt_r  <= stall_cnt_nxt;
      addr_r       <= addr_nxt;
      stall_done_r <= stall_done_nxt;
      in_burst_r   <= in_burst_nxt;
    end
  end

  // Output stage, all registered
  logic        sb_nxt, aps_nxt, oe_n_nxt, stall_n_nxt;
  logic [15:0] dq_nxt;
  always_comb begin
    sb_nxt      = cs_n_r && (mode_r == MODE_ARRAY) && !busy;
    oe_n_nxt    = cs_n_r || out_en_n;
    stall_n_nxt = !(stall_cnt_nxt != 3'h0);
    aps_nxt     = idle_power_saving;
    dq_nxt      = dq_out;
    if (!cs_n_r) begin
      if (mode_r == MODE_ARRAY) begin
        // Hold last word at low power until array_data differs from it
        aps_nxt = (dq_out == array_data);
        dq_nxt  = array_data;
      end else begin
        aps_nxt = 1'b0;
        dq_nxt  = {8'h00, status_nxt};
      end
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      standby           <= 1'b0;
      dq_oe_n           <= 1'b1;
      stall_n           <= 1'b1;
      idle_power_saving <= 1'b0;
      dq_out            <= 16'h0000;
      operation_status  <= `SR_RESET;
      erase_go          <= 1'b0;
      erase_block       <= 5'h00;
    end else begin
      standby           <= sb_nxt;
      dq_oe_n           <= oe_n_nxt;
      stall_n           <= stall_n_nxt;
      idle_power_saving <= aps_nxt;
      dq_out            <= dq_nxt;
      operation_status  <= status_nxt;
      erase_go          <= go_nxt;
      erase_block       <= blk_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/flash_ctrl_cfg.svh
// Purpose: Constants for the flash command and protection controller
// Assumes: 10 MHz sys_clk
// Notes:   Offsets of status bits, command codes, timing counts
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH
`define CMD_ERASE_SETUP   8'h20
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_READ_ARRAY    8'hff
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_STATUS   8'h70
`define SR_READY          7
`define SR_ERASE_ERR      5
`define SR_SEQ_ERR        4
`define SR_SUPPLY_ERR     3
`define SR_LOCK_ERR       1
`define SR_RESET          8'h80
`define ERASE_TIME_US     100
`define CLK_MHZ           10
`define ERASE_CYCLES      (`ERASE_TIME_US * `CLK_MHZ)
`define LAT_RESET         3'h3
`endif

// ===== logic/flash_ctrl_pkg.sv
// Purpose: Types for the flash command and protection controller
// Assumes: Used with flash_ctrl_cfg.svh
// Notes:   Mode and state encodings
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_STATUS = 2'b01,
    MODE_SETUP  = 2'b10
  } read_mode_e;
  typedef enum logic [1:0] {
    WSM_IDLE  = 2'b00,
    WSM_ERASE = 2'b01
  } wsm_state_e;
  typedef logic [4:0] block_t;
endpackage

// ===== bench/flash_ctrl_monitor.sv
// Purpose: Port assertions for the flash controller
// Assumes: Bench runs with ERASE_CYCLES of 8
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_monitor #(
  parameter int ERASE_CYCLES = 8
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       write_n,
  input wire logic       burst_start,
  input wire logic       burst_continuous,
  input wire logic [2:0] latency_code,
  input wire logic [7:0] operation_status,
  input wire logic       dq_oe_n,
  input wire logic       stall_n,
  input wire logic       erase_go,
  input wire logic       standby
);
  logic [3:0] len_r, len_nxt, age_r, age_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  // Stall run length, stalls per burst, cycles since a write strobe
  always_comb begin
    len_nxt = stall_n ? 4'h0 : len_r + 4'h1;
    cnt_nxt = burst_start ? 2'h0 : cnt_r + {1'b0, !stall_n && len_r == 4'h0 && cnt_r != 2'h3};
    age_nxt = !write_n ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {len_r, age_r, cnt_r} <= '0;
    end else begin
      {len_r, age_r, cnt_r} <= {len_nxt, age_nxt, cnt_nxt};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_go_busy: assert property (erase_go |-> !operation_status[7])
    else $error("ready during launch");
  a_go_pulse: assert property (erase_go |=> !erase_go)
    else $error("launch not a pulse");
  a_busy_hold: assert property ($fell(operation_status[7]) |-> !operation_status[7] [*4])
    else $error("busy too short");
  a_seq_pair: assert property (operation_status[4] |-> operation_status[5])
    else $error("bit 4 alone");
  a_err_sticky: assert property ($fell(operation_status[5]) || $fell(operation_status[3])
    || $fell(operation_status[1]) |-> age_r < 4'hc)
    else $error("error bit dropped");
  a_stby_float: assert property (standby |-> dq_oe_n)
    else $error("driven in standby");
  a_stby_idle: assert property (standby |-> operation_status[7])
    else $error("standby while busy");
  a_stall_len: assert property ($rose(stall_n) |-> len_r == {1'b0, latency_code})
    else $error("stall length");
  a_stall_once: assert property (cnt_r <= 2'h1)
    else $error("second stall");
  a_stall_cont: assert property (!stall_n |-> burst_continuous)
    else $error("stall outside continuous");
  c_erase: cover property (erase_go);
  c_stall: cover property ($rose(stall_n));
  c_seq: cover property (operation_status[4]);
endmodule
bind flash_command_protection_ctrl flash_ctrl_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) i_mon (
  .sys_clk, .nrst, .write_n, .burst_start, .burst_continuous, .latency_code,
  .operation_status, .dq_oe_n, .stall_n, .erase_go, .standby);
`default_nettype wire

// ===== bench/array_core_model.sv
// Purpose: Array core behind the controller
// Assumes: One erase at a time
// Notes:   One block always fails its erase
`timescale 1ns/1ps
`default_nettype none
module array_core_model #(
  parameter logic [4:0] BAD_BLOCK = 5'h11
) (
  input wire logic        sys_clk,
  input wire logic        erase_go,
  input wire logic [4:0]  erase_block,
  output var logic        erase_fail,
  output var logic [15:0] array_data
);
  initial begin
    erase_fail = 1'b0;
    array_data = 16'h3c5a;
  end
  always @(posedge sys_clk) begin
    if (erase_go === 1'b1) begin
      erase_fail <= (erase_block == BAD_BLOCK);
      array_data <= ~array_data;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the flash controller
// Assumes: ERASE_CYCLES shortened to 8, top boot
// Notes:   Block 17 fails erase in the core model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, nrst = 0, chip_sel_n = 1, write_n = 1, out_en_n = 1;
  logic write_protect_n = 1, supply_ok = 1, burst_start = 0, burst_next = 0;
  logic burst_continuous = 0, erase_fail, dq_oe_n, stall_n, erase_go, idle_power_saving, standby;
  logic [7:0] cmd_data = 8'h00, operation_status;
  logic [4:0] cmd_block = 5'h00, erase_block, last_blk;
  logic [4:0] lk [3] = '{5'h00, 5'h15, 5'h16};
  logic [3:0] burst_addr = 4'h0;
  logic [2:0] latency_code = 3'h5;
  logic [15:0] dq_out, array_data;
  int err_count = 0, checks = 0, gos = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (erase_go === 1'b1) begin
      gos++;
      last_blk <= erase_block;
    end
  end
  flash_command_protection_ctrl #(.ERASE_CYCLES(8)) i_dut (.sys_clk, .nrst, .chip_sel_n,
    .write_n, .out_en_n, .write_protect_n, .supply_ok, .cmd_data, .cmd_block, .burst_start,
    .burst_next, .burst_continuous, .burst_addr, .latency_code, .erase_fail, .array_data,
    .operation_status, .dq_out, .dq_oe_n, .stall_n, .erase_go, .erase_block,
    .idle_power_saving, .standby);
  array_core_model i_core (.sys_clk, .erase_go, .erase_block, .erase_fail, .array_data);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] d, input logic [4:0] b, input logic cs);
    tick(1);
    cmd_data <= d;
    cmd_block <= b;
    chip_sel_n <= cs;
    write_n <= 1'b0;
    tick(6);
    write_n <= 1'b1;
    chip_sel_n <= 1'b1;
    tick(6);
  endtask
  task automatic clr;
    wr(8'h50, 5'h00, 1'b0);
    chk(operation_status, 8'h80);
  endtask
  task automatic erase_case(input logic [4:0] b, input logic wp, input logic sup,
      input logic [7:0] conf, input logic [7:0] exp, input logic [7:0] msk, input int go);
    int g;
    g = gos;
    write_protect_n <= wp;
    supply_ok <= sup;
    wr(8'h20, b, 1'b0);
    wr(conf, b, 1'b0);
    for (int i = 0; i < 60 && operation_status[7] !== 1'b1; i++) tick(1);
    chk(operation_status & msk, exp);
    chk(gos - g, go);
    if (go == 1) chk(last_blk, b);
  endtask
  task automatic inhibit;
    int g;
    g = gos;
    wr(8'h20, 5'h10, 1'b1);
    wr(8'hd0, 5'h10, 1'b1);
    chk(gos - g, 0);
    chk(operation_status, 8'h80);
  endtask
  task automatic read_back;
    chip_sel_n <= 1'b0;
    out_en_n <= 1'b0;
    tick(6);
    chk(dq_out[7:0], 8'h80);
    chk(dq_oe_n, 1'b0);
    wr(8'hff, 5'h00, 1'b0);
    chip_sel_n <= 1'b0;
    tick(8);
    chk(dq_out, array_data);
    chk(idle_power_saving, 1'b1);
    chip_sel_n <= 1'b1;
    tick(6);
    chk(standby, 1'b1);
    chk(dq_oe_n, 1'b1);
    out_en_n <= 1'b1;
  endtask
  task automatic burst(input logic [3:0] a, input int n, input int exp);
    int low;
    low = 0;
    tick(1);
    // Burst only runs while the synced chip select is low
    chip_sel_n <= 1'b0;
    tick(5);
    burst_continuous <= 1'b1;
    burst_addr <= a;
    burst_start <= 1'b1;
    tick(1);
    burst_start <= 1'b0;
    for (int i = 0; i < n + 12; i++) begin
      @(posedge sys_clk);
      burst_next <= (i < n);
      if (stall_n === 1'b0) low++;
    end
    chk(low, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    tick(15);
    chk(operation_status, 8'h80);
    chk(dq_oe_n, 1'b1);
    tick(1);
    nrst <= 1'b1;
    tick(4);
    chk(stall_n, 1'b1);
    inhibit();
    erase_case(5'h10, 1'b0, 1'b1, 8'hd0, 8'h80, 8'hff, 1);
    read_back();
    foreach (lk[i]) begin
      erase_case(lk[i], 1'b0, 1'b1, 8'hd0, 8'ha2, 8'hff, 0);
      clr();
    end
    erase_case(5'h11, 1'b1, 1'b1, 8'hd0, 8'ha0, 8'hff, 1);
    erase_case(5'h10, 1'b1, 1'b1, 8'hd0, 8'ha0, 8'hff, 1);
    clr();
    erase_case(5'h10, 1'b1, 1'b1, 8'h33, 8'hb0, 8'hff, 0);
    clr();
    erase_case(5'h10, 1'b1, 1'b0, 8'hd0, 8'h08, 8'h08, 0);
    clr();
    burst(4'h0, 20, 0);
    burst(4'h3, 16, 5);
    burst(4'h3, 40, 5);
    burst(4'h1, 8, 0);
    finish_test();
  end
  initial begin
    tick(5000);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
